// ### inc/mcm_pkg.sv
package mcm_pkg;

  // ----------------------------------------------------------------
  // Menu geometry and factory defaults
  // ----------------------------------------------------------------
  localparam logic [2:0] ALARM_LAST    = 3'h7;
  localparam logic [2:0] COMMS_LAST    = 3'h5;
  localparam logic [2:0] RDG_LAST      = 3'h6;
  localparam logic [2:0] SEL_FIRST     = 3'h0;
  localparam logic [7:0] ALARM_DEFAULT = 8'h00;
  localparam logic [5:0] COMMS_DEFAULT = 6'h00;
  localparam logic [6:0] RDG_DEFAULT   = 7'h09;

  // ----------------------------------------------------------------
  // Fixed point: 16.16 signed scale, integer display units
  // ----------------------------------------------------------------
  localparam int          FRAC_BITS   = 16;
  localparam logic [31:0] SCALE_ONE   = 32'h0001_0000;
  localparam logic [31:0] OFFSET_ZERO = 32'h0000_0000;
  localparam logic [5:0]  DIV_STEPS   = 6'h30;
  localparam logic [5:0]  DIV_LAST    = 6'h01;

  // ----------------------------------------------------------------
  // Register map, byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_SHADOW = 8'h04;
  localparam logic [7:0] REG_USCALE = 8'h08;
  localparam logic [7:0] REG_UOFFS  = 8'h0c;
  localparam logic [7:0] REG_IN1    = 8'h10;
  localparam logic [7:0] REG_RD1    = 8'h14;
  localparam logic [7:0] REG_IN2    = 8'h18;
  localparam logic [7:0] REG_RD2    = 8'h1c;
  localparam logic [7:0] REG_ESCALE = 8'h20;
  localparam logic [7:0] REG_EOFFS  = 8'h24;
  localparam logic [7:0] REG_DISP   = 8'h28;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    MENU_ALARM, MENU_COMMS, MENU_INPUT, MENU_RDG, MENU_SCALE
  } mcm_menu_t;

  typedef struct packed {
    logic reset_mode;
    logic scale_enable;
    logic temp_unit;
    logic leading_zero;
    logic brightness;
    logic decimal_point;
    logic scale_format;
  } mcm_rdg_t;

  typedef struct packed {
    logic commit;
    logic value;
    logic step;
  } mcm_btn_t;

endpackage

// ### hdl/mcm_menu.sv
// How it works
// - In a submenu step moves to the next bit and value flips the bit.
// - Commit in the alarm lockout menu stores all its bits, goes to comms.
// - The comms lockout menu has six bits stepped in ascending order.
// - Commit in the comms lockout menu stores its bits, goes to input.
// - Alarm lockout bits one to eight each lock one alarm/output item.
// - Comms lockout bits one to six each lock one communication item.
// - All alarm and comms lockout bits come out of reset unlocked.
// - The reading configuration menu has seven fields stepped upward.
// - Commit in reading configuration stores fields, goes to scale entry.
// - Scale format picks direct (0) or two-point (1) entry, default 1.
// - Decimal point and brightness fields select 0/1, both default 0.
// - Leading zeros shown at 0, suppressed at 1, default 1.
// - Display equals scale times input plus offset.
// - With scale enable 0 scale is forced to 1.0 and offset to 0.0.
// - External reset low: hard reset at mode 0, peak/valley clear at 1.
// - Two-point mode computes scale and offset from two entered pairs.
`timescale 1ns/1ps
module mcm_menu
  import mcm_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        step_btn_n,
  input  wire logic        value_btn_n,
  input  wire logic        commit_btn_n,
  input  wire logic        external_reset_input_n,
  input  wire logic [31:0] meas_value,
  output logic [7:0]       alarm_lockout_bits,
  output logic [5:0]       comms_lockout_bits,
  output mcm_rdg_t         rdg_cfg,
  output logic [31:0]      display_value,
  output logic             hard_reset_req,
  output logic             peak_valley_clr
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [3:0] s1_r, s2_r, s3_r, lvl_r, lvl_nxt;
  mcm_btn_t   press;

  always_comb begin
    lvl_nxt = lvl_r;
    for (int i = 0; i < 4; i++) begin
      if (s2_r[i] == s3_r[i]) begin
        lvl_nxt[i] = s3_r[i];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_r  <= 4'hf;
      s2_r  <= 4'hf;
      s3_r  <= 4'hf;
      lvl_r <= 4'hf;
    end else begin
      s1_r  <= {external_reset_input_n, commit_btn_n, value_btn_n,
                step_btn_n};
      s2_r  <= s1_r;
      s3_r  <= s2_r;
      lvl_r <= lvl_nxt;
    end
  end

  // Press is the falling edge of the agreed low-active level
  assign press = mcm_btn_t'(lvl_r[2:0] & ~lvl_nxt[2:0]);

  // ----------------------------------------------------------------
  // Menu walk, shadow and active configuration
  // ----------------------------------------------------------------
  mcm_menu_t  menu_r, menu_nxt;
  logic [2:0] sel_r, sel_nxt, last;
  logic [7:0] shadow_r, shadow_nxt;
  logic [7:0] alarm_r, alarm_nxt;
  logic [5:0] comms_r, comms_nxt;
  mcm_rdg_t   rdg_r, rdg_nxt;
  logic       rdg_commit;

  always_comb begin
    case (menu_r)
      MENU_ALARM: last = ALARM_LAST;
      MENU_COMMS: last = COMMS_LAST;
      MENU_RDG:   last = RDG_LAST;
      default:    last = SEL_FIRST;
    endcase
  end

  always_comb begin
    menu_nxt   = menu_r;
    sel_nxt    = sel_r;
    shadow_nxt = shadow_r;
    alarm_nxt  = alarm_r;
    comms_nxt  = comms_r;
    rdg_nxt    = rdg_r;
    rdg_commit = 1'b0;
    if (press.commit) begin
      sel_nxt = SEL_FIRST;
      case (menu_r)
        MENU_ALARM: begin
          alarm_nxt  = shadow_r;
          menu_nxt   = MENU_COMMS;
          shadow_nxt = {2'h0, comms_r};
        end
        MENU_COMMS: begin
          comms_nxt = shadow_r[5:0];
          menu_nxt  = MENU_INPUT;
        end
        MENU_INPUT: begin
          menu_nxt   = MENU_RDG;
          shadow_nxt = {1'b0, rdg_r};
        end
        MENU_RDG: begin
          rdg_nxt    = mcm_rdg_t'(shadow_r[6:0]);
          rdg_commit = 1'b1;
          menu_nxt   = MENU_SCALE;
        end
        MENU_SCALE: begin
          menu_nxt   = MENU_ALARM;
          shadow_nxt = alarm_r;
        end
        default: begin
          menu_nxt   = MENU_ALARM;
          shadow_nxt = alarm_r;
        end
      endcase
    end else if (press.value) begin
      if (menu_r == MENU_ALARM || menu_r == MENU_COMMS ||
          menu_r == MENU_RDG) begin
        shadow_nxt[sel_r] = ~shadow_r[sel_r];
      end
    end else if (press.step) begin
      sel_nxt = (sel_r == last) ? SEL_FIRST : sel_r + 3'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      menu_r   <= MENU_ALARM;
      sel_r    <= SEL_FIRST;
      shadow_r <= ALARM_DEFAULT;
      alarm_r  <= ALARM_DEFAULT;
      comms_r  <= COMMS_DEFAULT;
      rdg_r    <= mcm_rdg_t'(RDG_DEFAULT);
    end else begin
      menu_r   <= menu_nxt;
      sel_r    <= sel_nxt;
      shadow_r <= shadow_nxt;
      alarm_r  <= alarm_nxt;
      comms_r  <= comms_nxt;
      rdg_r    <= rdg_nxt;
    end
  end

  // Lock bits leave as vectors; each consumer gates its own item
  assign alarm_lockout_bits = alarm_r;
  assign comms_lockout_bits = comms_r;
  assign rdg_cfg            = rdg_r;

  // ----------------------------------------------------------------
  // External reset pin
  // ----------------------------------------------------------------
  logic hrst_r, hrst_nxt, pvclr_r, pvclr_nxt;

  always_comb begin
    hrst_nxt  = !lvl_r[3] && !rdg_r.reset_mode;
    pvclr_nxt = !lvl_r[3] && rdg_r.reset_mode;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hrst_r  <= 1'b0;
      pvclr_r <= 1'b0;
    end else begin
      hrst_r  <= hrst_nxt;
      pvclr_r <= pvclr_nxt;
    end
  end

  assign hard_reset_req  = hrst_r;
  assign peak_valley_clr = pvclr_r;

  // ----------------------------------------------------------------
  // APB slave, one wait state so every output is a flop
  // ----------------------------------------------------------------
  logic        rdy_r, rdy_nxt, err_r, err_nxt, wr_en;
  logic [31:0] rdata_r, rdata_nxt;
  logic [31:0] uscale_r, uoffs_r, in1_r, rd1_r, in2_r, rd2_r;
  logic [31:0] uscale_nxt, uoffs_nxt, in1_nxt, rd1_nxt, in2_nxt, rd2_nxt;
  logic [31:0] escale_r, eoffs_r, disp_r;
  logic        busy_r, coord_wr;

  assign wr_en = psel && penable && pwrite && rdy_r;

  always_comb begin
    rdy_nxt    = psel && penable && !rdy_r;
    err_nxt    = 1'b0;
    rdata_nxt  = 32'h0;
    uscale_nxt = uscale_r;
    uoffs_nxt  = uoffs_r;
    in1_nxt    = in1_r;
    rd1_nxt    = rd1_r;
    in2_nxt    = in2_r;
    rd2_nxt    = rd2_r;
    coord_wr   = 1'b0;
    case (paddr)
      REG_STATUS: rdata_nxt = {4'h0, busy_r, sel_r, menu_r, rdg_r,
                               comms_r, alarm_r};
      REG_SHADOW: rdata_nxt = {24'h0, shadow_r};
      REG_USCALE: rdata_nxt = uscale_r;
      REG_UOFFS:  rdata_nxt = uoffs_r;
      REG_IN1:    rdata_nxt = in1_r;
      REG_RD1:    rdata_nxt = rd1_r;
      REG_IN2:    rdata_nxt = in2_r;
      REG_RD2:    rdata_nxt = rd2_r;
      REG_ESCALE: rdata_nxt = escale_r;
      REG_EOFFS:  rdata_nxt = eoffs_r;
      REG_DISP:   rdata_nxt = disp_r;
      default:    err_nxt   = 1'b1;
    endcase
    if (wr_en) begin
      case (paddr)
        REG_USCALE: uscale_nxt = pwdata;
        REG_UOFFS:  uoffs_nxt  = pwdata;
        REG_IN1: begin
          in1_nxt  = pwdata;
          coord_wr = 1'b1;
        end
        REG_RD1: begin
          rd1_nxt  = pwdata;
          coord_wr = 1'b1;
        end
        REG_IN2: begin
          in2_nxt  = pwdata;
          coord_wr = 1'b1;
        end
        REG_RD2: begin
          rd2_nxt  = pwdata;
          coord_wr = 1'b1;
        end
        default: coord_wr = 1'b0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdy_r    <= 1'b0;
      err_r    <= 1'b0;
      rdata_r  <= 32'h0;
      uscale_r <= SCALE_ONE;
      uoffs_r  <= OFFSET_ZERO;
      in1_r    <= 32'h0;
      rd1_r    <= 32'h0;
      in2_r    <= 32'h0;
      rd2_r    <= 32'h0;
    end else begin
      rdy_r    <= rdy_nxt;
      err_r    <= err_nxt;
      rdata_r  <= rdata_nxt;
      uscale_r <= uscale_nxt;
      uoffs_r  <= uoffs_nxt;
      in1_r    <= in1_nxt;
      rd1_r    <= rd1_nxt;
      in2_r    <= in2_nxt;
      rd2_r    <= rd2_nxt;
    end
  end

  assign pready  = rdy_r;
  assign prdata  = rdata_r;
  assign pslverr = err_r;

  // ----------------------------------------------------------------
  // Two-point solver: restoring divide, then offset
  // ----------------------------------------------------------------
  logic [5:0]         cnt_r, cnt_nxt;
  logic [47:0]        num_r, num_nxt;
  logic [32:0]        rem_r, rem_nxt, rem_sh;
  logic [31:0]        den_r, den_nxt, cscale_r, cscale_nxt;
  logic [31:0]        coffs_r, coffs_nxt, d_in, d_rd, a_in, a_rd, q_s;
  logic               neg_r, neg_nxt, fin_r, fin_nxt, busy_nxt;
  logic               start_r, start_nxt;
  logic signed [63:0] p_i1;

  assign d_in   = in2_r - in1_r;
  assign d_rd   = rd2_r - rd1_r;
  assign a_in   = d_in[31] ? 32'h0 - d_in : d_in;
  assign a_rd   = d_rd[31] ? 32'h0 - d_rd : d_rd;
  assign rem_sh = {rem_r[31:0], num_r[47]};
  assign q_s    = neg_r ? 32'h0 - num_r[31:0] : num_r[31:0];
  assign p_i1   = $signed(q_s) * $signed(in1_r);

  always_comb begin
    cnt_nxt    = cnt_r;
    num_nxt    = num_r;
    rem_nxt    = rem_r;
    den_nxt    = den_r;
    neg_nxt    = neg_r;
    busy_nxt   = busy_r;
    fin_nxt    = 1'b0;
    cscale_nxt = cscale_r;
    coffs_nxt  = coffs_r;
    // Start a cycle late so the word just written is already stored
    start_nxt  = coord_wr || rdg_commit;
    // Equal inputs give no slope; the last good solution is kept
    if (start_r && d_in != 32'h0) begin
      num_nxt  = {a_rd, 16'h0};
      den_nxt  = a_in;
      rem_nxt  = 33'h0;
      neg_nxt  = d_in[31] ^ d_rd[31];
      cnt_nxt  = DIV_STEPS;
      busy_nxt = 1'b1;
    end else if (busy_r) begin
      if (rem_sh >= {1'b0, den_r}) begin
        rem_nxt = rem_sh - {1'b0, den_r};
        num_nxt = {num_r[46:0], 1'b1};
      end else begin
        rem_nxt = rem_sh;
        num_nxt = {num_r[46:0], 1'b0};
      end
      cnt_nxt = cnt_r - 6'h1;
      if (cnt_r == DIV_LAST) begin
        busy_nxt = 1'b0;
        fin_nxt  = 1'b1;
      end
    end else if (fin_r) begin
      cscale_nxt = q_s;
      coffs_nxt  = rd1_r - p_i1[FRAC_BITS +: 32];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r    <= 6'h0;
      num_r    <= 48'h0;
      rem_r    <= 33'h0;
      den_r    <= 32'h0;
      neg_r    <= 1'b0;
      busy_r   <= 1'b0;
      fin_r    <= 1'b0;
      cscale_r <= SCALE_ONE;
      coffs_r  <= OFFSET_ZERO;
      start_r  <= 1'b0;
    end else begin
      cnt_r    <= cnt_nxt;
      num_r    <= num_nxt;
      rem_r    <= rem_nxt;
      den_r    <= den_nxt;
      neg_r    <= neg_nxt;
      busy_r   <= busy_nxt;
      fin_r    <= fin_nxt;
      cscale_r <= cscale_nxt;
      coffs_r  <= coffs_nxt;
      start_r  <= start_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Effective scale/offset and display value
  // ----------------------------------------------------------------
  logic [31:0]        escale_nxt, eoffs_nxt, disp_nxt;
  logic signed [63:0] p_disp;

  assign p_disp = $signed(escale_r) * $signed(meas_value);

  always_comb begin
    if (!rdg_r.scale_enable) begin
      escale_nxt = SCALE_ONE;
      eoffs_nxt  = OFFSET_ZERO;
    end else if (rdg_r.scale_format) begin
      escale_nxt = cscale_r;
      eoffs_nxt  = coffs_r;
    end else begin
      escale_nxt = uscale_r;
      eoffs_nxt  = uoffs_r;
    end
    disp_nxt = p_disp[FRAC_BITS +: 32] + eoffs_r;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      escale_r <= SCALE_ONE;
      eoffs_r  <= OFFSET_ZERO;
      disp_r   <= 32'h0;
    end else begin
      escale_r <= escale_nxt;
      eoffs_r  <= eoffs_nxt;
      disp_r   <= disp_nxt;
    end
  end

  assign display_value = disp_r;

endmodule

// ### tb/mcm_menu_sva.sv
`timescale 1ns/1ps
module mcm_menu_sva
  import mcm_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [7:0]  paddr,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        commit_btn_n,
  input wire logic [7:0]  alarm_lockout_bits,
  input wire logic [5:0]  comms_lockout_bits,
  input wire mcm_rdg_t    rdg_cfg,
  input wire logic [31:0] meas_value,
  input wire logic [31:0] display_value,
  input wire logic        hard_reset_req,
  input wire logic        peak_valley_clr
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ----------------------------------------------------------------
  // Bus timing
  // ----------------------------------------------------------------
  a_pready_wait: assert property ((psel && !penable) ##1 (psel && penable)
    |=> pready) else $error("pready late");
  a_pready_pulse: assert property (pready |=> !pready)
    else $error("pready held");
  a_err_unmapped: assert property (pready && (paddr > 8'h28 ||
    paddr[1:0] != 2'h0) |-> pslverr) else $error("missing error");
  a_err_mapped: assert property (pready && paddr <= 8'h28 &&
    paddr[1:0] == 2'h0 |-> !pslverr) else $error("spurious error");

  // ----------------------------------------------------------------
  // Active bits move only on a commit press
  // ----------------------------------------------------------------
  a_alarm_commit: assert property ($changed(alarm_lockout_bits) |->
    !$past(commit_btn_n, 4) || !$past(commit_btn_n, 5))
    else $error("alarm bits changed without commit");
  a_comms_commit: assert property ($changed(comms_lockout_bits) |->
    !$past(commit_btn_n, 4) || !$past(commit_btn_n, 5))
    else $error("comms bits changed without commit");
  a_rdg_commit: assert property ($changed(rdg_cfg) |->
    !$past(commit_btn_n, 4) || !$past(commit_btn_n, 5))
    else $error("reading fields changed without commit");

  // ----------------------------------------------------------------
  // Reset pin and display
  // ----------------------------------------------------------------
  a_hard_mode: assert property (hard_reset_req |->
    !$past(rdg_cfg.reset_mode)) else $error("hard reset in mode 1");
  a_pv_mode: assert property (peak_valley_clr |->
    $past(rdg_cfg.reset_mode)) else $error("peak clear in mode 0");
  a_display_unity: assert property (!rdg_cfg.scale_enable [*4] |=>
    display_value == $past(meas_value)) else $error("unity scale broken");

  c_bus_err: cover property (pready && pslverr);
  c_pv_clr: cover property (peak_valley_clr);
  c_comms_set: cover property ($changed(comms_lockout_bits));
endmodule

bind mcm_menu mcm_menu_sva u_sva (.pclk, .presetn, .psel, .penable,
  .paddr, .pready, .pslverr, .commit_btn_n, .alarm_lockout_bits,
  .comms_lockout_bits, .rdg_cfg, .meas_value, .display_value,
  .hard_reset_req, .peak_valley_clr);

// ### tb/mcm_btn_person.sv
`timescale 1ns/1ps
module mcm_btn_person (
  input wire logic pclk,
  output logic     step_n,
  output logic     value_n,
  output logic     commit_n
);
  // Buttons idle released; the DUT needs two agreeing samples, so hold each press
  initial {commit_n, value_n, step_n} = 3'h7;

  task automatic press(input byte k);
    case (k)
      "s": step_n <= 1'b0;
      "v": value_n <= 1'b0;
      default: commit_n <= 1'b0;
    endcase
    repeat (6) @(posedge pclk);
    {commit_n, value_n, step_n} <= 3'h7;
    repeat (6) @(posedge pclk);
  endtask
endmodule

// ### tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import mcm_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr, alarm_lockout_bits;
  logic [31:0] pwdata, prdata, meas_value, display_value, rd;
  logic        step_n, value_n, commit_n, ext_n, hard_req, pv_clr;
  logic [5:0]  comms_lockout_bits;
  mcm_rdg_t    rdg_cfg;
  int          mismatches, check_count;

  mcm_btn_person u_person (.pclk(pclk), .step_n(step_n),
    .value_n(value_n), .commit_n(commit_n));

  mcm_menu DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .step_btn_n(step_n), .value_btn_n(value_n), .commit_btn_n(commit_n),
    .external_reset_input_n(ext_n), .meas_value(meas_value),
    .alarm_lockout_bits(alarm_lockout_bits),
    .comms_lockout_bits(comms_lockout_bits), .rdg_cfg(rdg_cfg),
    .display_value(display_value), .hard_reset_req(hard_req),
    .peak_valley_clr(pv_clr));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic give_verdict();
    if (mismatches == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Held until pready is sampled high; one idle edge between calls
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      chk(32'h0, 32'h1);
      give_verdict();
    end else begin
      rd      = prdata;
      err     = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  task automatic seq(input string s);
    for (int i = 0; i < s.len(); i++) u_person.press(s[i]);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {presetn, psel, penable, pwrite} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    meas_value = 32'h7;
    ext_n = 1'b1;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk(alarm_lockout_bits, 8'h00);
    chk(comms_lockout_bits, 6'h00);
    chk(rdg_cfg, 7'h09);
    apb(1'b0, REG_DISP, 32'h0);
    chk(rd, 32'h7);
    apb(1'b0, 8'h40, 32'h0);
    chk(err, 1'b1);
    ext_n <= 1'b0;
    repeat (6) @(posedge pclk);
    chk({hard_req, pv_clr}, 2'h2);
    ext_n <= 1'b1;
    repeat (6) @(posedge pclk);
    seq("vsv");
    apb(1'b0, REG_SHADOW, 32'h0);
    chk(rd[7:0], 8'h03);
    chk(alarm_lockout_bits, 8'h00);
    seq("c");
    chk(alarm_lockout_bits, 8'h03);
    apb(1'b0, REG_STATUS, 32'h0);
    chk(rd[23:21], 3'h1);
    // Six steps wrap back to the first comms bit
    seq("sssssvsv");
    apb(1'b0, REG_SHADOW, 32'h0);
    chk(rd[5:0], 6'h21);
    seq("c");
    chk(comms_lockout_bits, 6'h21);
    apb(1'b0, REG_STATUS, 32'h0);
    chk(rd[23:21], 3'h2);
    seq("cvsssssvsv");
    chk(rdg_cfg, 7'h09);
    seq("c");
    chk(rdg_cfg, 7'h68);
    apb(1'b0, REG_STATUS, 32'h0);
    chk(rd[23:21], 3'h4);
    apb(1'b1, REG_USCALE, 32'h0002_0000);
    apb(1'b1, REG_UOFFS, 32'h5);
    meas_value <= 32'h3;
    repeat (6) @(posedge pclk);
    chk(display_value, 32'hb);
    ext_n <= 1'b0;
    repeat (6) @(posedge pclk);
    chk({hard_req, pv_clr}, 2'h1);
    ext_n <= 1'b1;
    seq("ccccvc");
    chk(rdg_cfg, 7'h69);
    apb(1'b1, REG_IN1, 32'h0);
    apb(1'b1, REG_RD1, 32'ha);
    apb(1'b1, REG_IN2, 32'h2);
    apb(1'b1, REG_RD2, 32'h1e);
    repeat (60) @(posedge pclk);
    apb(1'b0, REG_ESCALE, 32'h0);
    chk(rd, 32'h000a_0000);
    chk(display_value, 32'h28);
    give_verdict();
  end
endmodule
